// *** vtsd_top.sv ***
// Video timing extractor and standard detector with an APB register slave.
//
// Local design decisions: the register addresses and the APB interface to the registers.
module vtsd_top import vtsd_pkg::*; #(
    parameter int FRAC_WIN_CYC = FRAC_WINDOW_CYC,
    parameter int FRAC_THRESH = FRAC_THRESH_WORDS,
    parameter int TRS_LOSS = TRS_LOSS_WORDS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Video word stream
    input wire logic video_valid_in,
    input wire logic [9:0] video_word_in,
    // Mode pins
    input wire logic cea_timing_select_pin_in,
    input wire logic processing_bypass_pin_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Status pins
    output logic [5:0] status_out
);
    localparam int CW = $clog2(FRAC_WIN_CYC + 1);
    localparam int LCW = $clog2(TRS_LOSS + 1);

    if (FRAC_WIN_CYC < 2 || FRAC_THRESH >= FRAC_WIN_CYC || TRS_LOSS < 8) begin : g_chk
        $error("vtsd_top: unusable parameter values");
    end

    logic [9:0] w1_q, w2_q, w3_q;
    logic is_xyz, eav, sav;
    logic [WW-1:0] samp_q, sav_pos_q;
    logic v_q, f_q, fseen_q, fld_f_q, v_rise;
    logic h_line_q, h_trs_q;
    logic [1:0] h_hold_q;
    logic [LW-1:0] lines_cnt_q, act_cnt_q, frame_line_q, fl_q;
    vtsd_raster_t line_meas_q, meas_q;
    logic meas_il_q;
    logic frame_start;
    logic [5:0] cand_code, prev_code_q;
    logic [1:0] frames_q;
    logic cand_lock;
    vtsd_raster_t raster_q;
    logic [5:0] code_q;
    logic lock_q, intl_q, frac_q;
    logic [CW-1:0] win_q, wcnt_q;
    logic frac_meas_q;
    logic [LCW-1:0] loss_q;
    logic trs_present_q;
    logic trs_drop;
    logic [1:0] ctrl_q;
    logic [23:0] pinsel_q;
    vtsd_cea_t cea;
    logic hs, vs, de, de_line;
    logic [WW-1:0] hs_end;
    logic [LW-1:0] vs_start, vs_end;
    logic [2:0] tim_d;
    logic [3:0] sig_vec;
    logic [5:0] status_d;
    logic publish;

    // Prefix matched on upper eight bits.
    assign is_xyz = video_valid_in && w3_q[9:2] == TRS_ONES && w2_q[9:2] == TRS_ZERO
                    && w1_q[9:2] == TRS_ZERO && video_word_in[9];
    assign eav = is_xyz && video_word_in[XYZ_H];
    assign sav = is_xyz && !video_word_in[XYZ_H];

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            w1_q <= 10'h000;
            w2_q <= 10'h000;
            w3_q <= 10'h000;
        end else if (video_valid_in) begin
            w1_q <= video_word_in;
            w2_q <= w1_q;
            w3_q <= w2_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            samp_q <= '0;
            sav_pos_q <= '0;
            h_line_q <= 1'b0;
            h_trs_q <= 1'b0;
            h_hold_q <= 2'h0;
        end else begin
            if (eav) begin
                samp_q <= '0;
            end else if (video_valid_in) begin
                samp_q <= samp_q + 1'b1;
            end
            if (sav) begin
                sav_pos_q <= samp_q;
            end
            if (eav) begin
                h_line_q <= 1'b1;
            end else if (sav) begin
                h_line_q <= 1'b0;
            end
            if (eav) begin
                h_trs_q <= 1'b1;
                h_hold_q <= 2'h0;
            end else if (sav) begin
                h_hold_q <= 2'h3;
            end else if (video_valid_in && h_hold_q != 2'h0) begin
                h_hold_q <= h_hold_q - 2'h1;
                if (h_hold_q == 2'h1) begin
                    h_trs_q <= 1'b0;
                end
            end
        end
    end

    // F is tracked per field so that progressive input still frames after interlaced input.
    assign v_rise = eav && !v_q && video_word_in[XYZ_V];
    assign frame_start = v_rise && (video_word_in[XYZ_F] || !fld_f_q);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            v_q <= 1'b0;
            f_q <= 1'b0;
            fseen_q <= 1'b0;
            fld_f_q <= 1'b0;
            lines_cnt_q <= '0;
            act_cnt_q <= '0;
            frame_line_q <= '0;
            fl_q <= '0;
            line_meas_q <= '0;
            meas_q <= '0;
            meas_il_q <= 1'b0;
        end else if (eav) begin
            v_q <= video_word_in[XYZ_V];
            f_q <= video_word_in[XYZ_F];
            fld_f_q <= v_rise ? video_word_in[XYZ_F] : fld_f_q | video_word_in[XYZ_F];
            line_meas_q.words_line <= samp_q + 1'b1;
            line_meas_q.active_words <= samp_q - sav_pos_q - 13'h0003;
            fl_q <= (v_q && !video_word_in[XYZ_V]) ? '0 : fl_q + 1'b1;
            if (frame_start) begin
                meas_q <= '{line_meas_q.words_line, line_meas_q.active_words,
                            lines_cnt_q, act_cnt_q};
                meas_il_q <= fseen_q;
                fseen_q <= video_word_in[XYZ_F];
                lines_cnt_q <= 11'h001;
                act_cnt_q <= '0;
                frame_line_q <= 11'h001;
            end else begin
                fseen_q <= fseen_q | video_word_in[XYZ_F];
                lines_cnt_q <= lines_cnt_q + 1'b1;
                act_cnt_q <= act_cnt_q + {10'h000, !video_word_in[XYZ_V]};
                frame_line_q <= frame_line_q + 1'b1;
            end
        end
    end

    assign cand_code = vtsd_classify(meas_q, meas_il_q);
    // Two matching frames, supported code, TRS present.
    assign cand_lock = trs_present_q && frames_q == 2'h2 && cand_code == prev_code_q
                       && cand_code != STD_UNK_HD && cand_code != STD_UNK_SD;
    assign publish = eav && frame_line_q == RASTER_UPDATE_LINE;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            prev_code_q <= STD_RST;
            frames_q <= 2'h0;
        end else if (frame_start) begin
            prev_code_q <= cand_code;
            frames_q <= (frames_q == 2'h2) ? frames_q : frames_q + 2'h1;
        end else if (!trs_present_q) begin
            frames_q <= 2'h0;
        end
    end

    // Cleared at reset and in bypass.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !processing_bypass_pin_in) begin
            raster_q <= '0;
            code_q <= STD_RST;
            lock_q <= 1'b0;
            intl_q <= 1'b0;
        end else if (!trs_present_q || trs_drop) begin
            // Lock falls on the same edge as TRS presence, never a cycle later.
            lock_q <= 1'b0;
        end else if (publish) begin
            raster_q <= meas_q;
            code_q <= cand_code;
            lock_q <= cand_lock;
            intl_q <= meas_il_q;
        end
    end

    // Word rate over a fixed window; SD rates follow the line count.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            win_q <= '0;
            wcnt_q <= '0;
            frac_meas_q <= 1'b0;
            frac_q <= 1'b0;
        end else begin
            if (win_q == CW'(FRAC_WIN_CYC - 1)) begin
                win_q <= '0;
                wcnt_q <= '0;
                frac_meas_q <= wcnt_q < CW'(FRAC_THRESH);
            end else begin
                win_q <= win_q + 1'b1;
                wcnt_q <= wcnt_q + {{(CW - 1){1'b0}}, video_valid_in};
            end
            if (publish) begin
                frac_q <= (meas_q.lines_frame == 11'h20D) ? 1'b1 :
                          (meas_q.lines_frame == 11'h271) ? 1'b0 : frac_meas_q;
            end
        end
    end

    // Loss watchdog counts words since last TRS.
    assign trs_drop = video_valid_in && !is_xyz && loss_q == LCW'(TRS_LOSS - 1);
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            loss_q <= '0;
            trs_present_q <= 1'b0;
        end else if (is_xyz) begin
            loss_q <= '0;
            trs_present_q <= 1'b1;
        end else if (video_valid_in) begin
            if (loss_q == LCW'(TRS_LOSS - 1)) begin
                trs_present_q <= 1'b0;
            end else begin
                loss_q <= loss_q + 1'b1;
            end
        end
    end

    assign cea = vtsd_cea_lookup(code_q);
    assign hs_end = cea.hfp + {5'h00, cea.hsw};
    assign vs_start = cea.vact + {7'h00, cea.vfp};
    assign vs_end = vs_start + {7'h00, cea.vsw};
    assign hs = samp_q >= cea.hfp && samp_q < hs_end;
    assign vs = fl_q >= vs_start && fl_q < vs_end;
    // Vertical blanking from TRS when selected.
    assign de_line = ctrl_q[CTRL_VFOLLOW_BIT] ? !v_q : fl_q < cea.vact;
    assign de = !h_line_q && de_line;

    // CEA sync replaces H, V, F.
    assign tim_d = !trs_present_q ? 3'h0 :
                   cea_timing_select_pin_in ? ((cea.ok && lock_q) ? {de, vs, hs} : 3'h0) :
                   {f_q, v_q, ctrl_q[CTRL_HCFG_BIT] ? h_trs_q : h_line_q};
    assign sig_vec = {lock_q, tim_d};

    // Per-pin routing, default H, V, F.
    for (genvar i = 0; i < 6; i++) begin : g_pin
        logic [3:0] sel;
        assign sel = pinsel_q[4 * i +: 4];
        assign status_d[i] = (sel <= SEL_LOCK) ? sig_vec[sel[1:0]] : 1'b0;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            status_out <= 6'h00;
        end else begin
            status_out <= status_d;
        end
    end

    // APB slave: one wait state, answer registered.
    logic apb_access, apb_take, addr_ok;
    logic [31:0] rd_d;
    assign apb_access = psel_in && penable_in && !pready_out;
    assign apb_take = psel_in && penable_in && pready_out;
    assign addr_ok = paddr_in == CTRL_OFS || paddr_in == PINSEL_OFS || paddr_in == STD_OFS
                     || paddr_in == RWPL_OFS || paddr_in == RAWL_OFS
                     || paddr_in == RLPF_OFS || paddr_in == RALF_OFS;
    assign rd_d = (paddr_in == CTRL_OFS) ? {30'h0, ctrl_q} :
                  (paddr_in == PINSEL_OFS) ? {8'h00, pinsel_q} :
                  (paddr_in == STD_OFS) ? {21'h0, frac_q, intl_q, lock_q, 2'h0, code_q} :
                  (paddr_in == RWPL_OFS) ? {19'h0, raster_q.words_line} :
                  (paddr_in == RAWL_OFS) ? {19'h0, raster_q.active_words} :
                  (paddr_in == RLPF_OFS) ? {21'h0, raster_q.lines_frame} :
                  (paddr_in == RALF_OFS) ? {21'h0, raster_q.active_lines} : 32'h0;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else begin
            pready_out <= apb_access;
            pslverr_out <= apb_access && !addr_ok;
            prdata_out <= (apb_access && !pwrite_in) ? rd_d : 32'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_q <= CTRL_RST;
            pinsel_q <= PINSEL_RST;
        end else if (apb_take && pwrite_in) begin
            if (paddr_in == CTRL_OFS) begin
                ctrl_q <= pwdata_in[1:0];
            end
            if (paddr_in == PINSEL_OFS) begin
                pinsel_q <= pwdata_in[23:0];
            end
        end
    end

    // Checks on the design's own behaviour.
    sequence s_sav_seen;
        sav ##1 (!is_xyz)[*3];
    endsequence

    bypass_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !processing_bypass_pin_in |=> code_q == STD_RST && !lock_q && !intl_q
        && raster_q == '0)
        else $error("status fields not cleared in bypass");

    eav_h_rise_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        eav && !cea_timing_select_pin_in |=> ##1 status_out[0] || pinsel_q[3:0] != SEL_H
        || !trs_present_q)
        else $error("H not raised after EAV");

    sav_h_fall_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_sav_seen and (video_valid_in[*4]) |=> !h_trs_q)
        else $error("TRS based H not released after SAV");

    no_trs_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !trs_present_q |=> status_out[2:0] == 3'h0 || pinsel_q[11:0] != PINSEL_RST[11:0])
        else $error("timing active without TRS");

    publish_only_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $changed(code_q) |-> $past(publish) || !$past(processing_bypass_pin_in))
        else $error("standard code changed outside line 12");

    lock_known_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        lock_q |-> code_q != STD_UNK_HD && code_q != STD_UNK_SD && trs_present_q)
        else $error("lock with unknown standard");

    cea_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cea_timing_select_pin_in && (!lock_q || !cea.ok) |=> status_out[2:0] == 3'h0
        || pinsel_q[11:0] != PINSEL_RST[11:0] || $past(lock_q, 1) != lock_q)
        else $error("CEA sync without supported locked format");

    apb_answer_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        psel_in && !penable_in ##1 psel_in && penable_in |=> pready_out ##1 !pready_out)
        else $error("APB answer not one wait state");

    intl_track_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        publish && processing_bypass_pin_in && trs_present_q |=> intl_q == $past(meas_il_q))
        else $error("interlace flag mismatch");
endmodule : vtsd_top

// *** vtsd_pkg.sv ***
// Constants, types and lookup functions for the video timing and standard detector.
package vtsd_pkg;
    localparam int WW = 13;
    localparam int LW = 11;
    typedef struct packed {
        logic [WW-1:0] words_line;
        logic [WW-1:0] active_words;
        logic [LW-1:0] lines_frame;
        logic [LW-1:0] active_lines;
    } vtsd_raster_t;
    typedef struct packed {
        logic ok;
        logic [WW-1:0] hfp;
        logic [7:0] hsw;
        logic [LW-1:0] vact;
        logic [3:0] vfp;
        logic [3:0] vsw;
    } vtsd_cea_t;
    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PINSEL_OFS = 8'h04;
    localparam logic [7:0] STD_OFS = 8'h08;
    localparam logic [7:0] RWPL_OFS = 8'h0C;
    localparam logic [7:0] RAWL_OFS = 8'h10;
    localparam logic [7:0] RLPF_OFS = 8'h14;
    localparam logic [7:0] RALF_OFS = 8'h18;
    localparam int CTRL_HCFG_BIT = 0;
    localparam int CTRL_VFOLLOW_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [23:0] PINSEL_RST = 24'h643210;
    localparam logic [3:0] SEL_H = 4'h0;
    localparam logic [3:0] SEL_V = 4'h1;
    localparam logic [3:0] SEL_F = 4'h2;
    localparam logic [3:0] SEL_LOCK = 4'h3;
    localparam int STANDARD_LOCKED_FLAG_BIT = 8;
    localparam int STD_INTL_BIT = 9;
    localparam int STD_FRAC_BIT = 10;
    localparam logic [7:0] TRS_ONES = 8'hFF;
    localparam logic [7:0] TRS_ZERO = 8'h00;
    localparam int XYZ_F = 8;
    localparam int XYZ_V = 7;
    localparam int XYZ_H = 6;
    localparam logic [LW-1:0] RASTER_UPDATE_LINE = 11'h00C;
    localparam logic [5:0] STD_UNK_HD = 6'h1D;
    localparam logic [5:0] STD_UNK_SD = 6'h1E;
    localparam logic [5:0] STD_RST = 6'h00;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FRAC_WINDOW_NS = 1000000;
    localparam int FRAC_WINDOW_CYC = FRAC_WINDOW_NS / CLK_PERIOD_NS;
    // Midpoint between 74250 and 74250/1.001 words per window.
    localparam int FRAC_THRESH_WORDS = 74213;
    localparam int TRS_LOSS_WORDS = 8800;

    function automatic logic [5:0] vtsd_classify(input vtsd_raster_t r, input logic il);
        logic [5:0] c;
        c = (r.words_line == 13'h06B4 || r.words_line == 13'h06C0) ? STD_UNK_SD : STD_UNK_HD;
        unique case (r.lines_frame)
            11'h465: begin
                unique case (r.words_line)
                    13'h0898: c = (r.active_lines == 11'h40B) ? 6'h15 : (il ? 6'h0A : 6'h0B);
                    13'h0A50: c = (r.active_words == 13'h0900) ? (il ? 6'h0F : 6'h0E)
                                                                : (il ? 6'h0C : 6'h0D);
                    13'h0ABE: c = (r.active_words == 13'h0960) ? (il ? 6'h13 : 6'h12)
                                                                : (il ? 6'h11 : 6'h10);
                    default: c = STD_UNK_HD;
                endcase
            end
            11'h4E2: c = 6'h14;
            11'h2EE: begin
                unique case (r.words_line)
                    13'h0672: c = (r.active_words == 13'h05A0) ? 6'h01 : 6'h00;
                    13'h07BC: c = (r.active_words == 13'h06C0) ? 6'h05 : 6'h04;
                    13'h0CE4: c = (r.active_words == 13'h0B40) ? 6'h03 : 6'h02;
                    13'h0F78: c = (r.active_words == 13'h0D80) ? 6'h07 : 6'h06;
                    13'h101D: c = (r.active_words == 13'h0E10) ? 6'h09 : 6'h08;
                    default: c = STD_UNK_HD;
                endcase
            end
            11'h20D: c = (r.active_words != 13'h05A0) ? 6'h19 :
                         (r.active_lines == 11'h1E7) ? 6'h16 :
                         (r.active_lines == 11'h1FB) ? 6'h17 : 6'h19;
            11'h271: c = (r.active_words == 13'h05A0) ? 6'h18 : 6'h1A;
            default: c = c;
        endcase
        return c;
    endfunction : vtsd_classify

    function automatic vtsd_cea_t vtsd_cea_lookup(input logic [5:0] c);
        vtsd_cea_t t;
        t = '0;
        unique case (c)
            6'h16, 6'h17, 6'h19, 6'h1B: t = '{1'b1, 13'h0026, 8'h7C, 11'h0F0, 4'h4, 4'h3};
            6'h18, 6'h1A: t = '{1'b1, 13'h0018, 8'h7E, 11'h120, 4'h2, 4'h3};
            6'h20, 6'h00: t = '{1'b1, 13'h006E, 8'h28, 11'h2D0, 4'h5, 4'h5};
            6'h24, 6'h04: t = '{1'b1, 13'h01B8, 8'h28, 11'h2D0, 4'h5, 4'h5};
            6'h2A, 6'h0A: t = '{1'b1, 13'h0058, 8'h2C, 11'h21C, 4'h2, 4'h5};
            6'h2C, 6'h0C: t = '{1'b1, 13'h0210, 8'h2C, 11'h21C, 4'h2, 4'h5};
            6'h2B, 6'h0B: t = '{1'b1, 13'h0058, 8'h2C, 11'h438, 4'h4, 4'h5};
            6'h2D, 6'h0D: t = '{1'b1, 13'h0210, 8'h2C, 11'h438, 4'h4, 4'h5};
            6'h30, 6'h10: t = '{1'b1, 13'h027E, 8'h2C, 11'h438, 4'h4, 4'h5};
            default: t = '0;
        endcase
        return t;
    endfunction : vtsd_cea_lookup
endpackage : vtsd_pkg

// *** vtsd_sink.sv ***
// Downstream sink model that counts horizontal blanking starts on the status pins.
module vtsd_sink (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Status pins from the detector
    input wire logic [5:0] status_in,
    output logic [15:0] h_starts_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic h_q;
    always_ff @(posedge clk_in) begin
        h_q <= status_in[0];
        if (!rst_n_in) h_starts_out <= 16'h0000;
        else if (status_in[0] && !h_q) h_starts_out <= h_starts_out + 16'h0001;
    end
endmodule : vtsd_sink

// *** vtsd_top_bench.sv ***
// Self-checking bench for the video timing and standard detector.
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module vtsd_top_bench import vtsd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, rst_n_in = 0, vvalid = 0, cea = 0, byp = 1;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [9:0] vword = 10'h000;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata_out, r;
    logic pready_out, pslverr_out, e;
    logic [5:0] status_out;
    logic [15:0] h_starts, h0;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    // Rows: 10-bit preamble, F, V, then expected status pins.
    logic [8:0] rows [4] = '{9'b000000001, 9'b101000011, 9'b010000101, 9'b111000111};
    always #5 clk_in = ~clk_in;
    // Small window and loss counts keep the run short.
    vtsd_top #(.FRAC_WIN_CYC(1000), .FRAC_THRESH(742), .TRS_LOSS(64)) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .video_valid_in(vvalid),
        .video_word_in(vword), .cea_timing_select_pin_in(cea),
        .processing_bypass_pin_in(byp), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .status_out(status_out));
    vtsd_sink sink (.clk_in(clk_in), .rst_n_in(rst_n_in), .status_in(status_out),
        .h_starts_out(h_starts));
    task automatic end_sim();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n == 20) fail_count++;
        r = prdata_out;
        e = pslverr_out;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic vw(input logic [9:0] w);
        @(posedge clk_in);
        vvalid <= 1;
        vword <= w;
    endtask : vw
    task automatic trs(input logic f, v, h, b10);
        vw(b10 ? 10'h3FF : 10'h3FC);
        vw(10'h000);
        vw(10'h000);
        vw({1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, b10, b10});
    endtask : trs
    task automatic line(input logic f, v);
        trs(f, v, 1, 1);
        repeat (4) vw(10'h200);
        trs(f, v, 0, 1);
        repeat (20) vw(10'h040);
    endtask : line
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1;
        apb(0, CTRL_OFS, 0);
        `CHK("ctrl", 32'h0, r)
        apb(0, PINSEL_OFS, 0);
        `CHK("pinsel", 32'h643210, r)
        apb(1, STD_OFS, 32'h3F);
        apb(0, STD_OFS, 0);
        `CHK("std", 32'h0, r)
        apb(0, 8'h40, 0);
        `CHK("unmapped", 2'b10, {e, r[0]})
        $display("test registers done");
        foreach (rows[i]) begin
            trs(rows[i][7], rows[i][6], 1, rows[i][8]);
            vw(10'h200);
            vw(10'h200);
            #1 `CHK("hvf", rows[i][5:0], status_out)
        end
        $display("test rows done");
        for (int c = 0; c < 2; c++) begin
            apb(1, CTRL_OFS, c);
            trs(0, 0, 1, 1);
            vw(10'h200);
            trs(0, 0, 0, 1);
            vw(10'h040);
            vw(10'h040);
            #1 `CHK("h_sav", c[0], status_out[0])
            repeat (6) vw(10'h040);
            #1 `CHK("h_end", 1'b0, status_out[0])
        end
        apb(1, CTRL_OFS, 0);
        $display("test h select done");
        apb(1, PINSEL_OFS, 32'h000120);
        trs(1, 0, 1, 1);
        vw(10'h200);
        vw(10'h200);
        #1 `CHK("route", 6'b111011, status_out)
        apb(1, PINSEL_OFS, 32'h643210);
        $display("test routing done");
        // Close the open blanking so the first line of the run makes an H edge.
        trs(0, 0, 0, 1);
        h0 = h_starts;
        repeat (3) for (int l = 0; l < 16; l++) line(0, l < 2);
        @(posedge clk_in);
        vvalid <= 0;
        `CHK("h_starts", h0 + 16'h0030, h_starts)
        apb(0, STD_OFS, 0);
        `CHK("std", {21'h0, 3'b000, 2'b00, STD_UNK_HD}, r)
        apb(0, RWPL_OFS, 0);
        `CHK("words", 32'h20, r)
        apb(0, RLPF_OFS, 0);
        `CHK("lines", 32'h10, r)
        // Two fields of eight lines, F high in the second, make an interlaced frame.
        repeat (3) for (int l = 0; l < 16; l++) line(l[3], l[2:0] < 2);
        @(posedge clk_in);
        vvalid <= 0;
        apb(0, STD_OFS, 0);
        `CHK("std_il", {21'h0, 3'b010, 2'b00, STD_UNK_HD}, r)
        apb(0, RLPF_OFS, 0);
        `CHK("lines_il", 32'h10, r)
        byp <= 0;
        apb(0, STD_OFS, 0);
        `CHK("byp_std", 32'h0, r)
        apb(0, RWPL_OFS, 0);
        `CHK("byp_words", 32'h0, r)
        byp <= 1;
        $display("test raster done");
        cea <= 1;
        trs(0, 1, 1, 1);
        vw(10'h200);
        vw(10'h200);
        #1 `CHK("cea_unlocked", 3'b000, status_out[2:0])
        @(posedge clk_in);
        cea <= 0;
        trs(1, 1, 1, 0);
        repeat (80) vw(10'h200);
        #1 `CHK("trs_loss", 6'h00, status_out)
        $display("test cea and loss done");
        end_sim();
    end
endmodule : vtsd_top_bench
